// ### dv/pmic_host_model.sv
// processor and push-button model driving button and hold-on
`timescale 1ns/1ps
module pmic_host_model (
  input  wire logic i_mclk,
  output logic      o_push_button_in_n,
  output logic      o_hold_on
);
  initial begin
    o_push_button_in_n = 1'b1;
    o_hold_on          = 1'b0;
  end
  task automatic button(input logic pressed);
    @(posedge i_mclk);
    o_push_button_in_n <= !pressed;
  endtask
  task automatic hold(input logic hi);
    @(posedge i_mclk);
    o_hold_on <= hi;
  endtask
  // raise hold-on first, then let the button go
  task automatic release_kept();
    hold(1'b1);
    button(1'b0);
  endtask
endmodule

// ### dv/pmic_power_state_control_props.sv
// assertion checker for the power-state control block ports
`timescale 1ns/1ps
module pmic_power_state_control_props
  import pmic_power_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = 20
) (
  input  wire logic         i_mclk,
  input  wire logic         i_arst_n,
  input  wire logic         i_read,
  input  wire logic         i_write,
  input  wire logic         o_waitrequest,
  input  wire logic         i_push_button_in_n,
  input  wire logic         i_hold_on,
  input  wire logic         i_sys_above_uvlo,
  input  wire logic         i_led_boost_enable_pin,
  input  wire rail_status_t i_rails,
  input  wire logic         o_power_good_oe_n,
  input  wire logic         o_button_wake_oe_n,
  input  wire logic         o_system_rail_en,
  input  wire logic         o_ext_regulator_enable_out,
  input  wire logic [1:0]   o_undervolt_sel,
  input  wire logic         o_host_if_active,
  input  wire power_ctl_t   o_ctl
);
  // continuous button-low sample count
  int unsigned low_cnt;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n || i_push_button_in_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////
  sequence s_debounced;
    low_cnt == DEBOUNCE_CYC + 2;
  endsequence
  sequence s_off_held;
    !o_system_rail_en ##1 !o_system_rail_en;
  endsequence
  a_pg_low_off: assert property (s_off_held |-> !o_power_good_oe_n)
    else $error("power good released while off");
  a_wake_early: assert property (low_cnt inside {[1:DEBOUNCE_CYC-1]} |-> o_button_wake_oe_n)
    else $error("wake driven before debounce");
  a_wake_debounced: assert property (s_debounced |-> !o_button_wake_oe_n)
    else $error("wake not driven after debounce");
  a_wake_release: assert property (i_push_button_in_n |=> o_button_wake_oe_n)
    else $error("wake not released");
  a_on_needs_uvlo: assert property ($rose(o_system_rail_en) |-> $past(i_sys_above_uvlo))
    else $error("started below lockout");
  a_uvlo_off: assert property (o_system_rail_en && !i_sys_above_uvlo |-> ##[1:3] !o_system_rail_en)
    else $error("no lockout shutdown");
  a_release_off: assert property ($rose(i_push_button_in_n) && !i_hold_on && o_host_if_active
    |-> ##[1:3] !o_system_rail_en)
    else $error("no shutdown on release");
  a_hold_drop: assert property ($fell(i_hold_on) && !i_push_button_in_n && o_system_rail_en
    |-> ##[1:3] !o_system_rail_en)
    else $error("no shutdown on hold drop");
  a_boost_off: assert property (s_off_held |-> !o_ctl.led_boost_en)
    else $error("boost on while off");
  a_boost_pin: assert property (o_host_if_active && i_led_boost_enable_pin |=> o_ctl.led_boost_en)
    else $error("boost pin ignored");
  a_tsd_bucks: assert property (|i_rails.rail_tsd |=> o_ctl.buck_en == 3'h0)
    else $error("bucks on during thermal event");
  a_ext_off: assert property (s_off_held |-> !o_ext_regulator_enable_out)
    else $error("ext enable high while off");
  a_uvsel_clear: assert property (s_off_held |-> o_undervolt_sel == 2'h0)
    else $error("lockout select kept in off");
  a_bus_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus answer late");
endmodule

// ### dv/pmic_power_state_control_tb.sv
// self-checking bench for the power-state control block
`timescale 1ns/1ps
module pmic_power_state_control_tb;
  import pmic_power_pkg::*;
  logic i_mclk, i_arst_n, i_read, i_write, i_usb_ac_present, i_sys_above_uvlo, i_led_pin;
  logic [3:0] i_address, be;
  logic [31:0] i_writedata, o_readdata, rd;
  logic o_waitrequest, o_pg_out, o_pg_oe_n, o_wake_out, o_wake_oe_n, o_rail_en, o_ext_en, o_host_if;
  logic btn_n, hold_on, prev;
  logic [1:0] o_uv_sel;
  rail_status_t i_rails;
  power_ctl_t o_ctl;
  int mismatches = 0, cmp_count = 0, cyc = 0, falls, fall_at;
  logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h1E, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
  logic [7:0] adc_v [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
  pmic_power_state_control #(.DEBOUNCE_CYC(20), .LONGPRESS_CYC(200), .PG_PULSE_CYC(10),
    .PG_UNIT_CYC(2), .SEQ_STEP_CYC(4)) u_pmic_power_state_control (
    .i_mclk, .i_arst_n, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable(be),
    .o_readdata, .o_waitrequest, .i_push_button_in_n(btn_n), .i_hold_on(hold_on),
    .i_usb_ac_present, .i_sys_above_uvlo, .i_led_boost_enable_pin(i_led_pin), .i_rails,
    .o_power_good_out(o_pg_out), .o_power_good_oe_n(o_pg_oe_n), .o_button_wake_out(o_wake_out),
    .o_button_wake_oe_n(o_wake_oe_n), .o_system_rail_en(o_rail_en),
    .o_ext_regulator_enable_out(o_ext_en), .o_undervolt_sel(o_uv_sel),
    .o_host_if_active(o_host_if), .o_ctl);
  pmic_host_model u_pmic_host_model (.i_mclk, .o_push_button_in_n(btn_n), .o_hold_on(hold_on));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_address <= a;
    i_writedata <= {24'hA5A5A5, d};
    i_write <= wr;
    i_read <= !wr;
    do begin
      @(posedge i_mclk);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {i_arst_n, i_read, i_write, i_usb_ac_present, i_led_pin, i_address} = '0;
    i_writedata = 32'h0;
    be = 4'hF;
    i_sys_above_uvlo = 1'b1;
    i_rails = 10'h3E0;
    repeat (4) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    wt(1);
    check(o_ctl.current_set_resistor_b, 1'b1);
    check({o_pg_out, o_wake_out, o_pg_oe_n, o_wake_oe_n}, 4'h1);
    for (int k = 0; k < 10; k++) if (k != 7) begin
      bus(1'b0, k[3:0], 8'h00);
      check(rd, {24'h0, rst_tab[k]});
    end
    bus(1'b1, 4'h0, 8'h18);
    bus(1'b0, 4'h0, 8'h00);
    check(rd, 32'h0);
    u_pmic_host_model.button(1'b1);
    wt(10);
    u_pmic_host_model.button(1'b0);
    wt(30);
    check(o_wake_oe_n, 1'b1);
    check(o_rail_en, 1'b0);
    u_pmic_host_model.button(1'b1);
    wt(25);
    check(o_wake_oe_n, 1'b0);
    check(o_rail_en, 1'b1);
    wt(30);
    bus(1'b0, 4'h7, 8'h00);
    check(rd[2:0], ST_ON);
    check(o_ctl.buck_en, 3'h7);
    check(o_ext_en, 1'b0);
    u_pmic_host_model.release_kept();
    wt(3);
    check(o_wake_oe_n, 1'b1);
    check(o_rail_en, 1'b1);
    bus(1'b1, 4'h2, 8'h1F);
    wt(20);
    check(o_pg_oe_n, 1'b1);
    for (int k = 0; k < 5; k++) begin
      @(posedge i_mclk) i_rails.rail_good[k] <= 1'b0;
      wt(2);
      check(o_pg_oe_n, 1'b0);
      @(posedge i_mclk) i_rails.rail_good[k] <= 1'b1;
    end
    wt(4);
    check(o_pg_oe_n, 1'b0);
    wt(10);
    check(o_pg_oe_n, 1'b1);
    bus(1'b1, 4'h4, 8'h85);
    wt(1);
    check({o_ctl.current_set_resistor_a, o_ctl.current_set_resistor_b}, 2'b10);
    check(o_ctl.led_pwm_duty, 7'h05);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h6, adc_v[k]);
      wt(2);
      check(o_ctl.adc_ref_en, k != 3);
    end
    bus(1'b1, 4'h0, 8'h18);
    bus(1'b1, 4'h5, 8'h80);
    wt(2);
    check({o_ctl.linreg1_en, o_ctl.linreg2_en, o_ctl.linreg2_follow}, 3'b111);
    bus(1'b1, 4'h3, 8'h80);
    wt(2);
    check(o_ctl.led_boost_en, 1'b1);
    bus(1'b1, 4'h3, 8'h00);
    wt(2);
    check(o_ctl.led_boost_en, 1'b0);
    @(posedge i_mclk) be <= 4'hE;
    bus(1'b1, 4'h3, 8'h80);
    wt(2);
    check(o_ctl.led_boost_en, 1'b0);
    @(posedge i_mclk) be <= 4'hF;
    @(posedge i_mclk) i_led_pin <= 1'b1;
    bus(1'b1, 4'h1, 8'h02);
    wt(1);
    check(o_uv_sel, 2'h2);
    check(o_ctl.led_boost_en, 1'b1);
    for (int k = 0; k < 5; k++) begin
      @(posedge i_mclk) i_rails.rail_tsd[k] <= 1'b1;
      wt(2);
      check(o_ctl.buck_en, 3'h0);
      @(posedge i_mclk) i_rails.rail_tsd[k] <= 1'b0;
      wt(2);
      check(o_ctl.buck_en, 3'h7);
    end
    u_pmic_host_model.button(1'b1);
    falls = 0;
    fall_at = 0;
    prev = o_pg_oe_n;
    for (int k = 0; k < 450; k++) begin
      wt(1);
      if (o_pg_oe_n === 1'b0 && falls == 0) fall_at = k;
      if (o_pg_oe_n === 1'b0 && prev === 1'b1) falls++;
      prev = o_pg_oe_n;
    end
    check(falls, 1);
    check(fall_at >= 198 && fall_at <= 204, 1'b1);
    bus(1'b0, 4'h4, 8'h00);
    check(rd, 32'h1E);
    check(o_ctl.led_pwm_duty, 7'h1E);
    bus(1'b1, 4'h1, 8'h01);
    check(o_uv_sel, 2'h1);
    @(posedge i_mclk) i_led_pin <= 1'b0;
    u_pmic_host_model.hold(1'b0);
    u_pmic_host_model.button(1'b0);
    wt(3);
    check({o_rail_en, o_ctl.buck_en, o_ext_en, o_uv_sel}, 7'h00);
    @(posedge i_mclk) i_usb_ac_present <= 1'b1;
    u_pmic_host_model.hold(1'b1);
    wt(6);
    check(o_rail_en, 1'b1);
    bus(1'b1, 4'h0, 8'h07);
    bus(1'b1, 4'h5, 8'h02);
    wt(30);
    bus(1'b0, 4'h7, 8'h00);
    check(rd[2:0], ST_ON2);
    check(o_ext_en, 1'b1);
    @(posedge i_mclk) i_sys_above_uvlo <= 1'b0;
    wt(3);
    check({o_rail_en, o_ext_en}, 2'b00);
    @(posedge i_mclk) {i_sys_above_uvlo, i_usb_ac_present} <= 2'b10;
    u_pmic_host_model.hold(1'b0);
    u_pmic_host_model.button(1'b1);
    wt(60);
    check(o_host_if, 1'b1);
    u_pmic_host_model.button(1'b0);
    wt(3);
    check(o_rail_en, 1'b0);
    report_and_stop();
  end
endmodule
bind pmic_power_state_control pmic_power_state_control_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (
  .i_mclk, .i_arst_n, .i_read, .i_write, .o_waitrequest, .i_push_button_in_n, .i_hold_on,
  .i_sys_above_uvlo, .i_led_boost_enable_pin, .i_rails, .o_power_good_oe_n, .o_button_wake_oe_n,
  .o_system_rail_en, .o_ext_regulator_enable_out, .o_undervolt_sel, .o_host_if_active, .o_ctl);

// ### verilog/pmic_power_consts.svh
// constants for the power-state control block
`ifndef PMIC_POWER_CONSTS_SVH
`define PMIC_POWER_CONSTS_SVH

`define CLK_FREQ_HZ        200000000
`define DEBOUNCE_MS        50
`define DEBOUNCE_CYC       ((`CLK_FREQ_HZ / 1000) * `DEBOUNCE_MS)
`define LONGPRESS_S        15
`define LONGPRESS_CYC      (`CLK_FREQ_HZ * `LONGPRESS_S)
`define PG_PULSE_US        500
`define PG_PULSE_CYC       ((`CLK_FREQ_HZ / 1000000) * `PG_PULSE_US)
`define PG_DELAY_CYC_DEF   1000
`define SEQ_STEP_CYC_DEF   1000

`define ADDR_CTRL1         4'h0
`define ADDR_CTRL2         4'h1
`define ADDR_MASK          4'h2
`define ADDR_LEDCTL1       4'h3
`define ADDR_LEDCTL2       4'h4
`define ADDR_LINREG        4'h5
`define ADDR_ADCCFG        4'h6
`define ADDR_STATUS        4'h7
`define ADDR_PGDELAY       4'h8

`define RST_CTRL1          8'h00
`define RST_CTRL2          8'h00
`define RST_MASK           8'h00
`define RST_LEDCTL1        8'h00
`define RST_LEDCTL2        8'h1E
`define RST_LINREG         8'h00
`define RST_ADCCFG         8'h00
`define RST_PGDELAY        8'h04
`define LED_DUTY_PIN_DEF   7'h1E

`define SEQ_EXT_A_BUCK     3'h7
`define SEQ_EXT_A_LIN      3'h2
`define SEQ_EXT_B_BUCK     3'h4
`define SEQ_EXT_B_LIN      3'h7

`define RAIL_COUNT         5
`endif

// ### verilog/pmic_power_pkg.sv
// types for the power-state control block
package pmic_power_pkg;
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_RAMP    = 3'b001,
    ST_LOAD    = 3'b011,
    ST_SEQ     = 3'b010,
    ST_ON      = 3'b110,
    ST_ON2     = 3'b111
  } power_state_t;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] mask;
    logic [7:0] ledctl1;
    logic [7:0] ledctl2;
    logic [7:0] linreg;
    logic [7:0] adccfg;
    logic [7:0] pgdelay;
  } reg_file_t;

  typedef struct packed {
    logic [4:0] rail_good;
    logic [4:0] rail_tsd;
  } rail_status_t;

  typedef struct packed {
    logic [2:0] buck_en;
    logic       linreg1_en;
    logic       linreg2_en;
    logic       linreg2_follow;
    logic       led_boost_en;
    logic       current_set_resistor_a;
    logic       current_set_resistor_b;
    logic [6:0] led_pwm_duty;
    logic       adc_ref_en;
  } power_ctl_t;
endpackage

// ### verilog/pmic_power_state_control.sv
// power-state control: button, lockout, power good, sequencing, LED and reference enables
// Operation
// - power good held low while any masked rail is below target
// - power good released only after configured delay once masked rails good
// - leave OFF on debounced button low with system rail above lockout
// - on ON entry ramp system rail, load defaults, then sequence regulators
// - host interface writes and LED boost usable only while ON or sequencing; reads work in every state
// - turn off on button release without hold-on, or on undervoltage
// - undervoltage select bits set threshold and persist until OFF or a long-press reset
// - after 15 s continuous press pulse power good low 0.5 ms
// - only one long-press pulse per continuous press
// - long-press pulse resets every register to default
// - wake output low after debounced press, released when button high
// - hold-on falling while button low shuts down immediately
// - hold-on rising with USB or AC power leaves OFF; hold-on high enters second ON state
// - LED boost on when enable pin high or sink enable bit set
// - pin-enabled LED boost dims at 30 percent default duty
// - external regulator enable rises during start-up, falls at OFF
// - external regulator enable used only for two sequencing code pairs
// - any thermal shutdown disables all buck converters until it clears
// - linear regulators follow own bits; tracking bit makes second follow buck three
// - current-level bit picks resistor a when 1, b when 0, reset 0
// - seven-bit duty field and current-level bit written together
// - ADC reference forced on by ADC, touch, or reference bit
`timescale 1ns/1ps
`include "pmic_power_consts.svh"

module pmic_power_state_control
  import pmic_power_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC  = `DEBOUNCE_CYC,
  parameter int unsigned LONGPRESS_CYC = `LONGPRESS_CYC,
  parameter int unsigned PG_PULSE_CYC  = `PG_PULSE_CYC,
  parameter int unsigned PG_UNIT_CYC   = `PG_DELAY_CYC_DEF,
  parameter int unsigned SEQ_STEP_CYC  = `SEQ_STEP_CYC_DEF
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_arst_n,
  input  wire logic [3:0]            i_address,
  input  wire logic                  i_read,
  input  wire logic                  i_write,
  input  wire logic [31:0]           i_writedata,
  input  wire logic [3:0]            i_byteenable,
  output logic      [31:0]           o_readdata,
  output logic                       o_waitrequest,
  input  wire logic                  i_push_button_in_n,
  input  wire logic                  i_hold_on,
  input  wire logic                  i_usb_ac_present,
  input  wire logic                  i_sys_above_uvlo,
  input  wire logic                  i_led_boost_enable_pin,
  input  wire rail_status_t          i_rails,
  output logic                       o_power_good_out,
  output logic                       o_power_good_oe_n,
  output logic                       o_button_wake_out,
  output logic                       o_button_wake_oe_n,
  output logic                       o_system_rail_en,
  output logic                       o_ext_regulator_enable_out,
  output logic [1:0]                 o_undervolt_sel,
  output logic                       o_host_if_active,
  output power_ctl_t                 o_ctl
);

  if (DEBOUNCE_CYC < 1 || LONGPRESS_CYC <= DEBOUNCE_CYC || PG_PULSE_CYC < 1 ||
      PG_UNIT_CYC < 1 || SEQ_STEP_CYC < 1 || PG_UNIT_CYC > 32'h00FF_FFFF) begin : g_bad_timing
    $error("pmic_power_state_control: bad timing parameters");
  end

  typedef struct packed {
    power_state_t state;
    reg_file_t    regs;
    logic [31:0]  deb_cnt;
    logic         pressed;
    logic [31:0]  lp_cnt;
    logic         lp_done;
    logic [31:0]  pulse_cnt;
    logic [31:0]  pg_cnt;
    logic         pg_rel;
    logic [31:0]  seq_cnt;
    logic [1:0]   seq_step;
    logic         ext_en;
    logic         hold_q;
    logic         ack;
    logic [31:0]  rdata;
    power_ctl_t   ctl;
  } state_t;

  state_t st_reg;
  state_t st_next;

  localparam reg_file_t REG_DEF = '{ctrl1: `RST_CTRL1, ctrl2: `RST_CTRL2, mask: `RST_MASK,
                                    ledctl1: `RST_LEDCTL1, ledctl2: `RST_LEDCTL2,
                                    linreg: `RST_LINREG, adccfg: `RST_ADCCFG,
                                    pgdelay: `RST_PGDELAY};

  logic       on_state;
  logic       masked_low;
  logic       tsd_any;
  logic       use_ext;
  logic [2:0] buck_sq;
  logic [2:0] lin_sq;
  logic [7:0] wbyte;
  logic       wr_acc;
  logic       rd_acc;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next    = st_reg;
    on_state   = (st_reg.state == ST_ON) || (st_reg.state == ST_ON2) ||
                 (st_reg.state == ST_SEQ);
    masked_low = |(st_reg.regs.mask[4:0] & ~i_rails.rail_good);
    tsd_any    = |i_rails.rail_tsd;
    buck_sq    = st_reg.regs.ctrl1[2:0];
    lin_sq     = st_reg.regs.linreg[2:0];
    use_ext    = (buck_sq == `SEQ_EXT_A_BUCK && lin_sq == `SEQ_EXT_A_LIN) ||
                 (buck_sq == `SEQ_EXT_B_BUCK && lin_sq == `SEQ_EXT_B_LIN);
    wbyte      = i_writedata[7:0];
    wr_acc     = i_write && !st_reg.ack && i_byteenable[0] && on_state;
    rd_acc     = i_read && !st_reg.ack;
    st_next.hold_q = i_hold_on;

    // debounce, restart on any high
    if (i_push_button_in_n) begin
      st_next.deb_cnt = '0;
      st_next.pressed = 1'b0;
      st_next.lp_cnt  = '0;
      st_next.lp_done = 1'b0;
    end else if (!st_reg.pressed) begin
      if (st_reg.deb_cnt >= DEBOUNCE_CYC - 1)
        st_next.pressed = 1'b1;
      else
        st_next.deb_cnt = st_reg.deb_cnt + 32'h1;
    end

    // long-press timer, once per press
    if (!i_push_button_in_n && !st_reg.lp_done) begin
      if (st_reg.lp_cnt >= LONGPRESS_CYC - 1) begin
        st_next.lp_done   = 1'b1;
        st_next.pulse_cnt = PG_PULSE_CYC;
        st_next.regs      = REG_DEF;
      end else
        st_next.lp_cnt = st_reg.lp_cnt + 32'h1;
    end
    if (st_reg.pulse_cnt != '0)
      st_next.pulse_cnt = st_reg.pulse_cnt - 32'h1;

    // power good delay
    if (masked_low || !on_state) begin
      st_next.pg_cnt = '0;
      st_next.pg_rel = 1'b0;
    end else if (!st_reg.pg_rel) begin
      if (st_reg.pg_cnt >= PG_UNIT_CYC * st_reg.regs.pgdelay)
        st_next.pg_rel = 1'b1;
      else
        st_next.pg_cnt = st_reg.pg_cnt + 32'h1;
    end

    // state machine
    case (st_reg.state)
      ST_OFF: begin
        st_next.ext_en = 1'b0;
        st_next.ctl.buck_en = 3'h0;
        if (i_sys_above_uvlo && (st_reg.pressed ||
            (i_hold_on && !st_reg.hold_q && i_usb_ac_present))) begin
          st_next.state   = ST_RAMP;
          st_next.seq_cnt = '0;
        end
      end
      ST_RAMP: begin
        if (st_reg.seq_cnt >= SEQ_STEP_CYC - 1) begin
          st_next.state   = ST_LOAD;
          st_next.seq_cnt = '0;
        end else
          st_next.seq_cnt = st_reg.seq_cnt + 32'h1;
      end
      ST_LOAD: begin
        st_next.regs     = REG_DEF;
        st_next.regs.ctrl2[1:0] = st_reg.regs.ctrl2[1:0];
        st_next.state    = ST_SEQ;
        st_next.seq_step = 2'h0;
      end
      ST_SEQ: begin
        if (st_reg.seq_cnt >= SEQ_STEP_CYC - 1) begin
          st_next.seq_cnt = '0;
          st_next.ctl.buck_en[st_reg.seq_step] = 1'b1;
          if (st_reg.seq_step == 2'h2) begin
            st_next.ext_en = use_ext;
            st_next.state  = i_hold_on ? ST_ON2 : ST_ON;
          end else
            st_next.seq_step = st_reg.seq_step + 2'h1;
        end else
          st_next.seq_cnt = st_reg.seq_cnt + 32'h1;
      end
      ST_ON: if (i_hold_on) st_next.state = ST_ON2;
      ST_ON2: ;
      default: st_next.state = ST_OFF;
    endcase

    if (st_reg.state != ST_OFF) begin
      if (!i_sys_above_uvlo ||
          (i_push_button_in_n && !i_hold_on && st_reg.state != ST_ON2) ||
          (!i_hold_on && st_reg.hold_q && !i_push_button_in_n) ||
          (st_reg.state == ST_ON2 && !i_hold_on)) begin
        st_next.state       = ST_OFF;
        st_next.ctl.buck_en = 3'h0;
        st_next.ext_en      = 1'b0;
        st_next.regs.ctrl2[1:0] = REG_DEF.ctrl2[1:0];
      end
    end

    // register writes
    if (wr_acc) begin
      if (i_address == `ADDR_CTRL1)
        st_next.regs.ctrl1 = wbyte;
      else if (i_address == `ADDR_CTRL2)
        st_next.regs.ctrl2 = wbyte;
      else if (i_address == `ADDR_MASK)
        st_next.regs.mask = wbyte;
      else if (i_address == `ADDR_LEDCTL1)
        st_next.regs.ledctl1 = wbyte;
      else if (i_address == `ADDR_LEDCTL2)
        st_next.regs.ledctl2 = wbyte;
      else if (i_address == `ADDR_LINREG)
        st_next.regs.linreg = wbyte;
      else if (i_address == `ADDR_ADCCFG)
        st_next.regs.adccfg = wbyte;
      else if (i_address == `ADDR_PGDELAY)
        st_next.regs.pgdelay = wbyte;
    end

    // register reads
    st_next.ack   = (i_read || i_write) && !st_reg.ack;
    st_next.rdata = 32'h0;
    if (rd_acc) begin
      if (i_address == `ADDR_CTRL1)
        st_next.rdata = {24'h0, st_reg.regs.ctrl1};
      else if (i_address == `ADDR_CTRL2)
        st_next.rdata = {24'h0, st_reg.regs.ctrl2};
      else if (i_address == `ADDR_MASK)
        st_next.rdata = {24'h0, st_reg.regs.mask};
      else if (i_address == `ADDR_LEDCTL1)
        st_next.rdata = {24'h0, st_reg.regs.ledctl1};
      else if (i_address == `ADDR_LEDCTL2)
        st_next.rdata = {24'h0, st_reg.regs.ledctl2};
      else if (i_address == `ADDR_LINREG)
        st_next.rdata = {24'h0, st_reg.regs.linreg};
      else if (i_address == `ADDR_ADCCFG)
        st_next.rdata = {24'h0, st_reg.regs.adccfg};
      else if (i_address == `ADDR_STATUS)
        st_next.rdata = {18'h0, st_reg.pg_rel, st_reg.pressed, st_reg.ext_en,
                         st_reg.ctl.buck_en, i_rails.rail_good, st_reg.state};
      else if (i_address == `ADDR_PGDELAY)
        st_next.rdata = {24'h0, st_reg.regs.pgdelay};
    end

    // derived enables
    if (tsd_any)
      st_next.ctl.buck_en = 3'h0;
    else if (st_reg.state == ST_ON || st_reg.state == ST_ON2)
      st_next.ctl.buck_en = 3'h7;
    st_next.ctl.linreg1_en     = on_state && st_reg.regs.ctrl1[3];
    st_next.ctl.linreg2_en     = on_state && st_reg.regs.ctrl1[4];
    st_next.ctl.linreg2_follow = st_reg.regs.linreg[7];
    st_next.ctl.led_boost_en   = on_state &&
                                 (i_led_boost_enable_pin || st_reg.regs.ledctl1[7]);
    st_next.ctl.current_set_resistor_a = st_reg.regs.ledctl2[7];
    st_next.ctl.current_set_resistor_b = !st_reg.regs.ledctl2[7];
    st_next.ctl.led_pwm_duty = (i_led_boost_enable_pin && !st_reg.regs.ledctl1[7]) ?
                               `LED_DUTY_PIN_DEF : st_reg.regs.ledctl2[6:0];
    st_next.ctl.adc_ref_en = st_reg.regs.adccfg[7] || st_reg.regs.adccfg[6] ||
                             st_reg.regs.adccfg[5];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg       <= '0;
      st_reg.regs  <= REG_DEF;
      st_reg.hold_q <= 1'b0;
      st_reg.ctl.current_set_resistor_b <= 1'b1;
      st_reg.ctl.led_pwm_duty <= REG_DEF.ledctl2[6:0];
    end else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_readdata                 = st_reg.rdata;
  assign o_waitrequest              = !st_reg.ack;
  assign o_power_good_out           = 1'b0;
  assign o_power_good_oe_n          = st_reg.pg_rel && (st_reg.pulse_cnt == '0);
  assign o_button_wake_out          = 1'b0;
  assign o_button_wake_oe_n         = !st_reg.pressed;
  assign o_system_rail_en           = st_reg.state != ST_OFF;
  assign o_ext_regulator_enable_out = st_reg.ext_en;
  assign o_undervolt_sel            = st_reg.regs.ctrl2[1:0];
  assign o_host_if_active           = on_state;
  assign o_ctl                      = st_reg.ctl;

endmodule
